//--- ssi_device.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// position sample queue, registered head so the reader sees a flop
module pos_fifo #(
   parameter int unsigned W     = 24,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic          push;
   logic          pop;
   logic          valid_d;

   // head register reloads when empty or consumed
   assign push = in_valid_i && in_ready_o;
   assign pop  = (cnt_q != '0) && (!out_valid_o || out_ready_i);
   // head register is one of the DEPTH slots, so it counts toward full
   assign valid_d = pop || (out_valid_o && !out_ready_i);

   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   // storage array has no reset; only written slots are ever read
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_q       <= '0;
         rd_q       <= '0;
         cnt_q      <= '0;
         in_ready_o <= 1'b0;
      end else begin
         cnt_q      <= cnt_d;
         in_ready_o <= ((cnt_d + CW'(valid_d)) != FULL_CNT);
         if (push) begin
            wr_q <= (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
         end
      end
   end

   // output stage
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
      end else if (pop) begin
         out_valid_o <= 1'b1;
         out_data_o  <= mem_q[rd_q];
      end else if (out_ready_i) begin
         out_valid_o <= 1'b0;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// device end: latches a position word per frame and shifts it out
module ssi_device
   import ssi_pkg::*;
#(
   parameter int unsigned POS_W      = POS_W_DEF,
   parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF,
   parameter bit          GRAY_CODE  = 1'b0
) (
   input  wire logic             CLK_I,
   input  wire logic             RST_N_I,
   input  wire logic             POS_VALID_I,
   output logic                  POS_READY_O,
   input  wire logic [POS_W-1:0] POS_I,
   output logic                  BUSY_O,
   output logic                  STALE_O,
   ssi_link_if.dev               LINK
);
   localparam int unsigned   BW       = $clog2(POS_W + 1);
   localparam logic [BW-1:0] BITS_END = BW'(POS_W);
   localparam logic [MONO_W-1:0] MONO_LOAD = MONO_W'(MONO_CYC - 1);

   logic [POS_W-1:0]  head_data;
   logic              head_valid;
   logic              head_take_q;
   logic              fall_tgl_q;
   logic              fs1_q;
   logic              fs2_q;
   logic              fs3_q;
   logic              fall_ev;
   logic [MONO_W-1:0] mono_q;
   logic              run_q;
   logic [POS_W-1:0]  word_q;
   logic [BW-1:0]     bit_q;
   logic [POS_W-1:0]  sh_q;
   logic              data_q;

   function automatic logic [POS_W-1:0] encode(input logic [POS_W-1:0] b);
      encode = GRAY_CODE ? (b ^ (b >> 1)) : b;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // samples queue up here; the source stalls once all slots are taken
   pos_fifo #(
      .W     (POS_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (CLK_I),
      .rst_n_i     (RST_N_I),
      .in_valid_i  (POS_VALID_I),
      .in_ready_o  (POS_READY_O),
      .in_data_i   (POS_I),
      .out_valid_o (head_valid),
      .out_ready_i (head_take_q),
      .out_data_o  (head_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // link domain: every falling serial clock edge flips a toggle
   always_ff @(negedge LINK.sclk or negedge RST_N_I) begin
      if (!RST_N_I) begin
         fall_tgl_q <= 1'b0;
      end else begin
         fall_tgl_q <= ~fall_tgl_q;
      end
   end

   // toggle crosses into the system clock; fs1 feeds only fs2
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         fs1_q <= 1'b0;
         fs2_q <= 1'b0;
         fs3_q <= 1'b0;
      end else begin
         fs1_q <= fall_tgl_q;
         fs2_q <= fs1_q;
         fs3_q <= fs2_q;
      end
   end

   assign fall_ev = fs2_q ^ fs3_q;

   ////////////////////////////////////////////////////////////////////////////
   // retriggerable monoflop; timed from the synchronised edge, so it
   // runs some 20-30 ns late against the pin, well inside tolerance
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mono_q <= '0;
         run_q  <= 1'b0;
      end else if (fall_ev) begin
         mono_q <= MONO_LOAD;
         run_q  <= 1'b1;
      end else if (mono_q != '0) begin
         mono_q <= mono_q - 1'b1;
      end else begin
         run_q  <= 1'b0;
      end
   end

   // capture only when the monoflop is freshly set; word stays frozen
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         word_q      <= '0;
         head_take_q <= 1'b0;
         STALE_O     <= 1'b0;
      end else begin
         head_take_q <= 1'b0;
         if (fall_ev && !run_q && !head_take_q) begin
            STALE_O <= !head_valid;
            if (head_valid) begin
               word_q      <= encode(head_data);
               head_take_q <= 1'b1;
            end
         end
      end
   end

   // busy mirrors the monoflop
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         BUSY_O <= 1'b0;
      end else begin
         BUSY_O <= run_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link domain shifter; monoflop expiry clears it, since the serial
   // clock stands still between frames. word_q is stable long before
   // the first rise (half a clock period after the first fall).
   always_ff @(posedge LINK.sclk or negedge run_q) begin
      if (!run_q) begin
         bit_q  <= '0;
         sh_q   <= '0;
         data_q <= IDLE_LEVEL;
      end else if (bit_q == '0) begin
         data_q <= word_q[POS_W-1];
         sh_q   <= word_q << 1;
         bit_q  <= bit_q + 1'b1;
      end else if (bit_q != BITS_END) begin
         data_q <= sh_q[POS_W-1];
         sh_q   <= sh_q << 1;
         bit_q  <= bit_q + 1'b1;
      end else begin
         data_q <= 1'b0;
      end
   end

   assign LINK.sdata = data_q;
endmodule

//--- ssi_pkg.sv
// Notes on behaviour
// - idle: clock and data both rest high
// - first clock fall starts 20 us monoflop
// - each further fall restarts the monoflop
// - latch position at monoflop set, hold frozen
// - first clock rise drives out the MSB
// - each later rise drives next lower bit
// - data low after sequence until monoflop expires
// - master pauses over 20 us between sequences
// - master samples first bit at second rise
// - master clocks one pulse more than bits
// - master clock between 80 and 820 kHz
// - master slows clock for cable delay
package ssi_pkg;

   localparam int unsigned CLK_PERIOD_NS           = 10;
   // monoflop_interval and inter_sequence_pause
   localparam int unsigned MONOFLOP_INTERVAL_NS    = 20000;
   localparam int unsigned MONO_CYC                = MONOFLOP_INTERVAL_NS / CLK_PERIOD_NS;
   localparam int unsigned MONO_W                  = 16;
   localparam int unsigned INTER_SEQUENCE_PAUSE_NS = 21000;
   localparam int unsigned PAUSE_CYC               =
      (INTER_SEQUENCE_PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // output_delay of the device and per-metre cable delay
   localparam int unsigned OUTPUT_DELAY_NS         = 100;
   localparam int unsigned CABLE_NS_PER_M          = 6;
   localparam int unsigned SYNC_STAGES             = 2;
   // serial clock limits
   localparam int unsigned FMIN_KHZ                = 80;
   localparam int unsigned FMAX_KHZ                = 820;
   localparam int unsigned CLK_KHZ_DEF             = 500;
   localparam int unsigned HALF_MIN_CYC            =
      (1000000 + 2 * FMAX_KHZ * CLK_PERIOD_NS - 1) / (2 * FMAX_KHZ * CLK_PERIOD_NS);
   localparam int unsigned HALF_MAX_CYC            =
      1000000 / (2 * FMIN_KHZ * CLK_PERIOD_NS);
   localparam int unsigned DIV_W                   = 16;
   // word format and buffering
   localparam int unsigned POS_W_DEF               = 24;
   localparam int unsigned FIFO_DEPTH_DEF          = 32;
   localparam logic        IDLE_LEVEL              = 1'b1;

   typedef enum logic [3:0] {
      M_IDLE  = 4'b0001,
      M_LOW   = 4'b0010,
      M_HIGH  = 4'b0100,
      M_PAUSE = 4'b1000
   } mst_state_t;

endpackage

//--- ssi_link_if.sv
`timescale 1ns/1ns
// serial clock from the master, serial data from the device
interface ssi_link_if;
   logic sclk;
   logic sdata;

   modport dev (
      input  sclk,
      output sdata
   );

   modport mst (
      output sclk,
      input  sdata
   );
endinterface

//--- ssi_master.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// master end: makes the serial clock by division and reads one word
module ssi_master
   import ssi_pkg::*;
#(
   parameter int unsigned POS_W   = POS_W_DEF,
   parameter int unsigned CLK_KHZ = CLK_KHZ_DEF,
   parameter int unsigned CABLE_M = 0
) (
   input  wire logic        CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic        EN_I,
   output logic [POS_W-1:0] WORD_O,
   output logic             WORD_STB_O,
   output logic             BUSY_O,
   ssi_link_if.mst          LINK
);
   // half period: asked rate, stretched for delays, kept in range
   localparam int unsigned HALF_REQ = (1000000 + 2 * CLK_KHZ * CLK_PERIOD_NS - 1)
                                      / (2 * CLK_KHZ * CLK_PERIOD_NS);
   localparam int unsigned DLY_NS   = OUTPUT_DELAY_NS + 2 * CABLE_NS_PER_M * CABLE_M;
   localparam int unsigned HALF_DLY = (DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                                      + SYNC_STAGES + 1;
   localparam int unsigned HALF_A   = (HALF_REQ > HALF_DLY) ? HALF_REQ : HALF_DLY;
   localparam int unsigned HALF_B   = (HALF_A > HALF_MIN_CYC) ? HALF_A : HALF_MIN_CYC;
   localparam int unsigned HALF     = (HALF_B < HALF_MAX_CYC) ? HALF_B : HALF_MAX_CYC;
   localparam logic [DIV_W-1:0] HALF_LOAD  = DIV_W'(HALF - 1);
   localparam logic [DIV_W-1:0] PAUSE_LOAD = DIV_W'(PAUSE_CYC - 1);
   localparam int unsigned   EW        = $clog2(POS_W + 2);
   localparam logic [EW-1:0] LAST_EDGE = EW'(POS_W + 1);

   mst_state_t       state_q;
   logic [DIV_W-1:0] div_q;
   logic [EW-1:0]    edge_q;
   logic [POS_W-1:0] shift_q;
   logic             sclk_q;
   logic             sd1_q;
   logic             sd2_q;

   ////////////////////////////////////////////////////////////////////////////
   // data pin comes from another domain; sd1 feeds only sd2
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sd1_q <= 1'b1;
         sd2_q <= 1'b1;
      end else begin
         sd1_q <= LINK.sdata;
         sd2_q <= sd1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock sequencer; sampling just before every rise but the first gives a full clock
   // period of settling for the device delay plus cable
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_q <= M_IDLE;
         div_q   <= '0;
         edge_q  <= '0;
         shift_q <= '0;
         sclk_q  <= IDLE_LEVEL;
      end else begin
         case (state_q)
            M_IDLE: begin
               sclk_q <= IDLE_LEVEL;
               edge_q <= '0;
               if (EN_I) begin
                  sclk_q  <= 1'b0;
                  div_q   <= HALF_LOAD;
                  state_q <= M_LOW;
               end
            end
            M_LOW: begin
               if (div_q != '0) begin
                  div_q <= div_q - 1'b1;
               end else begin
                  if (edge_q != '0) begin
                     shift_q <= {shift_q[POS_W-2:0], sd2_q};
                  end
                  sclk_q  <= 1'b1;
                  edge_q  <= edge_q + 1'b1;
                  div_q   <= HALF_LOAD;
                  state_q <= M_HIGH;
               end
            end
            M_HIGH: begin
               if (div_q != '0) begin
                  div_q <= div_q - 1'b1;
               end else if (edge_q == LAST_EDGE) begin
                  div_q   <= PAUSE_LOAD;
                  state_q <= M_PAUSE;
               end else begin
                  sclk_q  <= 1'b0;
                  div_q   <= HALF_LOAD;
                  state_q <= M_LOW;
               end
            end
            M_PAUSE: begin
               // clock held high long enough for the monoflop to run out
               if (div_q != '0) begin
                  div_q <= div_q - 1'b1;
               end else begin
                  state_q <= M_IDLE;
               end
            end
            default: begin
               state_q <= M_IDLE;
               sclk_q  <= IDLE_LEVEL;
            end
         endcase
      end
   end

   // word handed out once per sequence
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         WORD_O     <= '0;
         WORD_STB_O <= 1'b0;
         BUSY_O     <= 1'b0;
      end else begin
         WORD_STB_O <= 1'b0;
         BUSY_O     <= (state_q != M_IDLE);
         if (state_q == M_HIGH && div_q == '0 && edge_q == LAST_EDGE) begin
            WORD_O     <= shift_q;
            WORD_STB_O <= 1'b1;
         end
      end
   end

   assign LINK.sclk = sclk_q;
endmodule

//--- ssi_monitor.sv
`timescale 1ns/1ns
module ssi_monitor
   import ssi_pkg::*;
#(
   parameter int unsigned POS_W = POS_W_DEF
) (
   input  wire logic CLK_I,
   input  wire logic RST_N_I,
   input  wire logic sclk_i,
   input  wire logic sdata_i
);
   logic        sclk;
   logic        sdata;
   logic [11:0] since_fall_q;
   logic [11:0] lo_cnt_q;
   logic [5:0]  rise_cnt_q;
   logic        sclk_q;

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   // short local names for the watched link lines
   assign sclk  = sclk_i;
   assign sdata = sdata_i;

   ////////////////////////////////////////////////////////////////////////////
   // edge history of the link clock; reset looks like a long pause
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sclk_q       <= 1'b1;
         since_fall_q <= 12'hfff;
      end else begin
         sclk_q <= sclk;
         if (sclk_q && !sclk) begin
            since_fall_q <= 12'h000;
         end else if (since_fall_q != 12'hfff) begin
            since_fall_q <= since_fall_q + 12'h001;
         end
      end
   end

   // low phase length and rises per frame
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         lo_cnt_q   <= 12'h000;
         rise_cnt_q <= 6'h00;
      end else begin
         lo_cnt_q <= sclk ? 12'h000 : lo_cnt_q + 12'h001;
         if (sclk_q && !sclk && since_fall_q > MONO_CYC) begin
            rise_cnt_q <= 6'h00;
         end else if (!sclk_q && sclk) begin
            rise_cnt_q <= rise_cnt_q + 6'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_expire;
      $rose(sdata) && since_fall_q > 200;
   endsequence
   sequence s_before_first_rise;
      !sclk && rise_cnt_q == 0;
   endsequence

   AST_IDLE_HIGH: assert property (since_fall_q > MONO_CYC + 8 |-> sdata)
      else $error("data not high in idle");
   AST_NO_EARLY_DATA: assert property (s_before_first_rise |-> sdata)
      else $error("data moved before first rise");
   AST_MONO_EXPIRE: assert property (s_expire |-> since_fall_q inside {[MONO_CYC:MONO_CYC+8]})
      else $error("data released at wrong time");
   AST_HOLD_LOW: assert property (rise_cnt_q == POS_W + 1 && since_fall_q inside {[200:MONO_CYC-1]} |-> !sdata)
      else $error("data not low after sequence");
   AST_DATA_STEADY: assert property (!sclk && lo_cnt_q >= 1 |-> $stable(sdata))
      else $error("data changed during low phase");
   AST_PAUSE: assert property ($fell(sclk) |-> since_fall_q < 2 * HALF_MAX_CYC + 2 || since_fall_q > MONO_CYC)
      else $error("pause between sequences too short");
   AST_PULSES: assert property (since_fall_q == MONO_CYC |-> rise_cnt_q == POS_W + 1)
      else $error("wrong clock count in sequence");
   AST_HALF_LOW: assert property ($rose(sclk) |-> lo_cnt_q >= HALF_MIN_CYC - 1 && lo_cnt_q <= HALF_MAX_CYC)
      else $error("clock low phase out of range");
   AST_PERIOD: assert property ($fell(sclk) && since_fall_q < 2 * HALF_MAX_CYC + 2 |-> since_fall_q >= 2 * HALF_MIN_CYC - 1)
      else $error("clock period too short");
endmodule

//--- testbench.sv
`timescale 1ns/1ns
module testbench
   import ssi_pkg::*;
;
   typedef struct packed {logic push; logic [23:0] pos; logic [23:0] word; logic stale;} row_t;
   // last row finds the queue empty, so the previous word comes again
   localparam row_t ROWS [6] = '{
      '{1'b1, 24'ha5a5a5, 24'ha5a5a5, 1'b0}, '{1'b1, 24'h000001, 24'h000001, 1'b0},
      '{1'b1, 24'h800000, 24'h800000, 1'b0}, '{1'b1, 24'hffffff, 24'hffffff, 1'b0},
      '{1'b1, 24'h5a5a5a, 24'h5a5a5a, 1'b0}, '{1'b0, 24'h000000, 24'h5a5a5a, 1'b1}};

   logic        clk, rst_n, en, stb, busy_m, pos_valid, pos_ready, busy_d, stale;
   logic        pos_valid_b, ready_b, busy_b;
   logic [23:0] pos, word, pos_b, got;
   int          miscompares, check_count, cyc;

   ssi_link_if lnk();
   ssi_link_if lnk_b();

   ssi_device i_ssi_device (.CLK_I(clk), .RST_N_I(rst_n), .POS_VALID_I(pos_valid),
      .POS_READY_O(pos_ready), .POS_I(pos), .BUSY_O(busy_d), .STALE_O(stale), .LINK(lnk));
   ssi_master #(.CLK_KHZ(800), .CABLE_M(10)) i_ssi_master (.CLK_I(clk), .RST_N_I(rst_n),
      .EN_I(en), .WORD_O(word), .WORD_STB_O(stb), .BUSY_O(busy_m), .LINK(lnk));
   ssi_monitor #(.POS_W(POS_W_DEF)) i_ssi_monitor (.CLK_I(clk), .RST_N_I(rst_n),
      .sclk_i(lnk.sclk), .sdata_i(lnk.sdata));
   // second device faces the bench, which breaks the master's rules on purpose;
   // it sends gray code so that coding path is exercised too
   ssi_device #(.GRAY_CODE(1'b1)) i_ssi_device_b (.CLK_I(clk), .RST_N_I(rst_n),
      .POS_VALID_I(pos_valid_b),
      .POS_READY_O(ready_b), .POS_I(pos_b), .BUSY_O(busy_b), .STALE_O(), .LINK(lnk_b));

   ////////////////////////////////////////////////////////////////////////////
   initial clk = 1'b0;
   always #5 clk = ~clk;

   // hang guard, about twice the expected run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         miscompares++;
         end_sim();
      end
   end

   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // strobe is one cycle wide, so look at every edge
   task automatic get_word();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (stb !== 1'b1 && n < 9000);
      check("stb", 24'(stb), 24'h1);
   endtask

   // bench as master at a 125 ns period, far above the rated rate; the
   // device has no input filter, so it must still keep up
   task automatic frame_b(input int n);
      @(posedge clk);
      #3;
      for (int k = 1; k <= n; k++) begin
         lnk_b.sclk = 1'b0;
         #62;
         if (k > 1) got = {got[22:0], lnk_b.sdata};
         lnk_b.sclk = 1'b1;
         #63;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0; en = 1'b0; pos_valid = 1'b0; pos = '0; pos_valid_b = 1'b0;
      pos_b = '0; got = '0; lnk_b.sclk = 1'b1; miscompares = 0; check_count = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      // queue the words back to back, then let the master read them
      foreach (ROWS[i]) begin
         if (ROWS[i].push) begin
            pos <= ROWS[i].pos;
            pos_valid <= 1'b1;
            @(posedge clk);
         end
      end
      pos_valid <= 1'b0;
      check("ready", 24'(pos_ready), 24'h1);
      en <= 1'b1;
      foreach (ROWS[i]) begin
         get_word();
         check("busy_run", 24'({busy_m, busy_d}), 24'h3);
         check("word", word, ROWS[i].word);
         check("stale", 24'(stale), 24'(ROWS[i].stale));
         $display("row %0d done", i);
      end
      en <= 1'b0;
      // reset in mid-sequence: both lines must go back to idle
      repeat (2200) @(posedge clk);
      en <= 1'b1;
      repeat (1000) @(posedge clk);
      en <= 1'b0;
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      check("sclk", 24'(lnk.sclk), 24'h1);
      check("sdata", 24'(lnk.sdata), 24'h1);
      check("busy", 24'({busy_m, busy_d, stb, stale}), 24'h0);
      rst_n <= 1'b1;
      $display("reset test done");
      repeat (2) @(posedge clk);
      // fill the queue until refused; the last word is dropped
      for (int i = 0; i < 33; i++) begin
         pos_b <= 24'h3c0000 + 24'(i);
         pos_valid_b <= 1'b1;
         @(posedge clk);
      end
      pos_valid_b <= 1'b0;
      @(posedge clk);
      check("ready_full", 24'(ready_b), 24'h0);
      frame_b(25);
      check("word_b0", got, 24'h220000);
      check("busy_b", 24'(busy_b), 24'h1);
      #1000;
      check("sdata_low", 24'(lnk_b.sdata), 24'h0);
      check("ready_pop", 24'(ready_b), 24'h1);
      // too short a pause: monoflop retriggers, no fresh word
      #4000;
      frame_b(25);
      check("word_short", got, 24'h000000);
      #25000;
      check("sdata_idle", 24'(lnk_b.sdata), 24'h1);
      check("busy_idle", 24'(busy_b), 24'h0);
      frame_b(25);
      check("word_b1", got, 24'h220001);
      $display("link tests done");
      end_sim();
   end
endmodule
